// *** core/ext_bus_hold_and_write_buffer_ctrl.sv ***
// external bus hold arbitration, posted write queue and bus clock control
`timescale 1ns/10ps
`default_nettype none
module ext_bus_hold_and_write_buffer_ctrl #(
    parameter int AW = 16,                        // external address width
    parameter int DW = 16                         // external data width
) (
    input  wire logic          aclk,              // system clock, 200 MHz
    input  wire logic          aresetn,           // device reset, sync low
    // axi4-lite register port
    input  wire logic [11:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [11:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          protected_write_unlock, // register write unlock
    // cpu side access port
    input  wire logic          cpu_req,           // held until cpu_ready
    input  wire logic          cpu_we,
    input  wire logic [AW-1:0] cpu_addr,
    input  wire logic [DW-1:0] cpu_wdata,
    output logic               cpu_ready,         // low = stall
    output logic [DW-1:0]      cpu_rdata,
    // bus cycle engine port
    output logic               ext_start,         // one cycle, cycle begins
    output logic               ext_we,
    output logic [AW-1:0]      ext_addr,
    output logic [DW-1:0]      ext_wdata,
    input  wire logic          ext_done,          // one cycle, cycle ends
    input  wire logic [DW-1:0] ext_rdata,
    // pins
    input  wire logic          bus_request_n,     // outside master request
    output logic               bus_grant_n,       // grant to outside master
    output logic               bus_hiz,           // bus and strobes floated
    output logic               ext_bus_clock_out,
    output logic               timing_clock       // timing tick, one cycle
);
    // cpu side sequencing
    typedef enum logic [1:0] {
        C_IDLE  = 2'b00,                          // nothing outstanding
        C_WWAIT = 2'b01,                          // unposted write in flight
        C_RD    = 2'b10,                          // read waiting or running
        C_RDONE = 2'b11                           // read data captured
    } cpu_st_t;

    // whole state of the block
    typedef struct packed {
        logic                          rq_s1;     // request sync stages
        logic                          rq_s2;
        logic                          rq_s3;
        logic                          rq_lvl;    // filtered request level
        logic                          grant;     // 1 = outside master owns bus
        logic                          inhibit;
        logic                          ckdis;
        logic                          halve;
        logic [2:0]                    tsel;
        logic [1:0]                    depth;
        logic                          tcnt;      // timing divider phase
        logic                          hcnt;      // halving phase
        logic                          xclk;      // bus clock level
        logic [2:0][AW-1:0]            qaddr;     // write queue slots
        logic [2:0][DW-1:0]            qdata;
        logic [1:0]                    qhead;
        logic [1:0]                    qcnt;
        cpu_st_t                       cst;
        logic                          e_busy;    // bus cycle running
        logic                          e_rd;
        logic                          start;
        logic                          we;
        logic [AW-1:0]                 addr;
        logic [DW-1:0]                 wdata;
        logic [DW-1:0]                 rdata;
        logic                          aw_got;    // axi write halves held
        logic [11:0]                   aw_addr;
        logic                          w_got;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [1:0]                    rresp;
        logic [31:0]                   rd_word;
    } state_t;

    state_t s_q;                                  // registered state
    state_t s_d;                                  // next state
    logic   tick;                                 // timing clock tick
    logic   rise;                                 // bus clock rising now
    logic   do_start;                             // bus cycle begins
    logic   push;                                 // cpu write enters queue
    logic   full;                                 // queue at its depth
    logic   cfg_fire;                             // register write taken
    logic [31:0] cfg_word;                        // readable config word
    logic [31:0] new_word;                        // merged write value
    logic [1:0]  tail;                            // free slot index

    // queue slot index wrap, used for tail and head advance
    function automatic logic [1:0] slot_add(input logic [1:0] a, input logic [1:0] b);
        logic [2:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s > {1'b0, ext_bus_pkg::LAST_SLOT}) begin
            s = s - 3'(ext_bus_pkg::QUEUE_SLOTS);
        end
        return s[1:0];
    endfunction

    // readable view of the config register
    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[ext_bus_pkg::F_TSEL_LSB +: 3]  = s_q.tsel;
        cfg_word[ext_bus_pkg::F_GRANT]          = bus_grant_n; // RQ22
        cfg_word[ext_bus_pkg::F_REQ]            = s_q.rq_lvl;  // RQ1
        cfg_word[ext_bus_pkg::F_INHIBIT]        = s_q.inhibit;
        cfg_word[ext_bus_pkg::F_LEVEL_LSB +: 2] = s_q.qcnt;    // RQ8
        cfg_word[ext_bus_pkg::F_CKDIS]          = s_q.ckdis;
        cfg_word[ext_bus_pkg::F_HALVE]          = s_q.halve;
        cfg_word[ext_bus_pkg::F_DEPTH_LSB +: 2] = s_q.depth;
    end

    // next state
    always_comb begin
        s_d = s_q;
        // request pin: three stages, level moves once stages two and three agree
        s_d.rq_s1 = bus_request_n;
        s_d.rq_s2 = s_q.rq_s1;
        s_d.rq_s3 = s_q.rq_s2;
        if (s_q.rq_s2 == s_q.rq_s3) begin
            s_d.rq_lvl = s_q.rq_s3;                            // RQ1
        end

        // timing clock from system clock
        tick = (s_q.tsel == ext_bus_pkg::TSEL_DIV1) || s_q.tcnt; // RQ23
        s_d.tcnt = ~s_q.tcnt;
        // bus clock toggles each tick, or every other tick when halved
        rise = 1'b0;
        if (tick) begin
            s_d.hcnt = ~s_q.hcnt;
            if (!s_q.halve || s_q.hcnt) begin                  // RQ10
                s_d.xclk = ~s_q.xclk;
                rise     = ~s_q.xclk;
            end
        end

        // queue fill state; depth zero still uses one slot
        full = (s_q.depth == 2'h0) ? (s_q.qcnt != 2'h0)
                                   : (s_q.qcnt >= s_q.depth);  // RQ19
        tail = slot_add(s_q.qhead, s_q.qcnt);

        // bus engine: writes drain first, reads only on an empty queue
        do_start = !s_q.e_busy && rise && !s_q.grant &&
                   ((s_q.qcnt != 2'h0) || (s_q.cst == C_RD)); // RQ11 RQ18 RQ5
        s_d.start = do_start;
        if (do_start) begin
            s_d.e_busy = 1'b1;
            if (s_q.qcnt != 2'h0) begin
                // oldest entry leaves first
                s_d.e_rd  = 1'b0;                              // RQ17
                s_d.we    = 1'b1;
                s_d.addr  = s_q.qaddr[s_q.qhead];
                s_d.wdata = s_q.qdata[s_q.qhead];
                s_d.qhead = slot_add(s_q.qhead, 2'h1);
            end else begin
                s_d.e_rd  = 1'b1;
                s_d.we    = 1'b0;
                s_d.addr  = cpu_addr;
            end
        end else if (s_q.e_busy && ext_done) begin
            s_d.e_busy = 1'b0;
        end

        // cpu side; no access is taken while the outside master is granted the bus
        cpu_ready = 1'b0;
        push      = 1'b0;
        case (s_q.cst)
            C_IDLE: begin
                if (cpu_req && !s_q.grant && !full) begin      // RQ5 RQ19
                    if (cpu_we) begin
                        push = 1'b1;
                        if (s_q.depth == 2'h0) begin
                            s_d.cst = C_WWAIT;                 // RQ13
                        end else begin
                            cpu_ready = 1'b1;                  // RQ14 RQ15 RQ16
                        end
                    end else begin
                        s_d.cst = C_RD;                        // RQ18
                    end
                end
            end
            C_WWAIT: begin
                // released when the single write has finished on the bus
                if (s_q.e_busy && ext_done && !s_q.e_rd && s_q.qcnt == 2'h0) begin
                    cpu_ready = 1'b1;                          // RQ13
                    s_d.cst   = C_IDLE;
                end
            end
            C_RD: begin
                if (s_q.e_busy && s_q.e_rd && ext_done) begin
                    s_d.rdata = ext_rdata;
                    s_d.cst   = C_RDONE;
                end
            end
            C_RDONE: begin
                cpu_ready = 1'b1;                              // RQ18
                s_d.cst   = C_IDLE;
            end
            default: begin
                s_d.cst = C_IDLE;
            end
        endcase
        if (push) begin
            s_d.qaddr[tail] = cpu_addr;
            s_d.qdata[tail] = cpu_wdata;
        end
        s_d.qcnt = s_q.qcnt + {1'b0, push} - {1'b0, do_start && s_q.qcnt != 2'h0};

        // hold arbitration: grant only between bus cycles, drop as soon as inhibited
        s_d.grant = !s_q.rq_lvl && !s_q.inhibit &&
                    (s_q.grant || (!s_q.e_busy && !do_start)); // RQ6 RQ2

        // axi write address and data, taken in either order
        cfg_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        for (int i = 0; i < 4; i++) begin
            new_word[i*8 +: 8] = s_q.w_strb[i] ? s_q.w_data[i*8 +: 8] : cfg_word[i*8 +: 8];
        end
        if (cfg_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            if (s_q.aw_addr[11:2] != ext_bus_pkg::CFG_ADDR[11:2]) begin
                s_d.bresp = ext_bus_pkg::RESP_SLVERR;
            end else begin
                s_d.bresp = ext_bus_pkg::RESP_OKAY;
                // locked writes answer okay but change nothing
                if (protected_write_unlock) begin              // RQ21
                    s_d.tsel    = new_word[ext_bus_pkg::F_TSEL_LSB +: 3];
                    s_d.inhibit = new_word[ext_bus_pkg::F_INHIBIT];
                    s_d.ckdis   = new_word[ext_bus_pkg::F_CKDIS];
                    s_d.halve   = new_word[ext_bus_pkg::F_HALVE];
                    s_d.depth   = new_word[ext_bus_pkg::F_DEPTH_LSB +: 2];
                end
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // axi read, one at a time
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            if (s_axi_araddr[11:2] != ext_bus_pkg::CFG_ADDR[11:2]) begin
                s_d.rresp   = ext_bus_pkg::RESP_SLVERR;
                s_d.rd_word = 32'h0000_0000;
            end else begin
                s_d.rresp   = ext_bus_pkg::RESP_OKAY;
                s_d.rd_word = cfg_word;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // state register; reset leaves the bus to the outside master only if it requests
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q         <= '0;
            s_q.rq_s1   <= 1'b1;
            s_q.rq_s2   <= 1'b1;
            s_q.rq_s3   <= 1'b1;
            s_q.rq_lvl  <= 1'b1;
            s_q.inhibit <= ext_bus_pkg::INHIBIT_RST;           // RQ3
            s_q.ckdis   <= ext_bus_pkg::CKDIS_RST;             // RQ9
            s_q.halve   <= ext_bus_pkg::HALVE_RST;             // RQ10
            s_q.tsel    <= ext_bus_pkg::TSEL_RST;              // RQ23
            s_q.depth   <= ext_bus_pkg::DEPTH_RST;             // RQ13
            s_q.cst     <= C_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; in reset the pin follows the request directly
    assign bus_grant_n       = aresetn ? !s_q.grant : bus_request_n; // RQ4 RQ6
    assign bus_hiz           = aresetn ? s_q.grant : !bus_request_n; // RQ4 RQ2
    assign ext_bus_clock_out = s_q.xclk && !s_q.ckdis;          // RQ9
    assign timing_clock      = tick;
    assign ext_start         = s_q.start;
    assign ext_we            = s_q.we;
    assign ext_addr          = s_q.addr;
    assign ext_wdata         = s_q.wdata;
    assign cpu_rdata         = s_q.rdata;
    assign s_axi_awready     = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready      = !s_q.w_got && !s_q.bvalid;
    assign s_axi_bvalid      = s_q.bvalid;
    assign s_axi_bresp       = s_q.bresp;
    assign s_axi_arready     = !s_q.rvalid;
    assign s_axi_rvalid      = s_q.rvalid;
    assign s_axi_rresp       = s_q.rresp;
    assign s_axi_rdata       = s_q.rd_word;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_inhibit_drop: assert property (s_q.inhibit |=> bus_grant_n) // RQ2
        else $error("grant active while inhibited");
    // a bus cycle starting in the same cycle defers the grant until it ends
    a_auto_grant: assert property (!s_q.rq_lvl && !s_q.inhibit && !s_q.e_busy && !s_q.grant && !do_start
        |=> !bus_grant_n) // RQ6
        else $error("idle request not granted");
    a_no_start_held: assert property (s_q.start |-> !$past(s_q.grant)) // RQ5
        else $error("bus cycle started while granted");
    a_start_rising: assert property (s_q.start |-> s_q.xclk && !$past(s_q.xclk)) // RQ11
        else $error("bus cycle not on clock rise");
    a_read_drained: assert property (s_q.start && !s_q.we |-> $past(s_q.qcnt) == 2'h0) // RQ18
        else $error("read before writes drained");
    a_full_stall: assert property (s_q.cst == C_IDLE && full |-> !cpu_ready) // RQ19
        else $error("access taken on full queue");
    a_unposted_wait: assert property (s_q.cst == C_WWAIT && !ext_done |-> !cpu_ready) // RQ13
        else $error("unposted write released early");
    a_reset_values: assert property ($rose(aresetn) |-> !s_q.inhibit && s_q.halve
        && !s_q.ckdis && s_q.depth == 2'h0) // RQ3
        else $error("wrong config after reset");
    a_clock_off: assert property (s_q.ckdis |-> !ext_bus_clock_out) // RQ9
        else $error("bus clock runs while disabled");
    a_locked_write: assert property (cfg_fire && !protected_write_unlock
        |=> $stable(s_q.depth) && $stable(s_q.inhibit)) // RQ21
        else $error("locked write changed config");
    a_level_report: assert property (s_axi_arvalid && !s_q.rvalid && s_axi_araddr == 12'h000
        |=> s_axi_rdata[7:6] == $past(s_q.qcnt)) // RQ8
        else $error("level field wrong");

    c_queue_full: cover property (s_q.depth == 2'h3 && s_q.qcnt == 2'h3);
    c_granted: cover property (!bus_grant_n ##1 cpu_req && !cpu_ready);
    c_read_done: cover property (s_q.cst == C_RDONE);
endmodule
`default_nettype wire

// *** common/ext_bus_pkg.sv ***
// constants for the external bus hold and write queue control block
// What the document requires
// RQ1: status bit shows bus request pin level
// RQ2: inhibit while granted releases grant next cycle
// RQ3: reset clears grant inhibit bit
// RQ4: request low in reset floats bus, grants
// RQ5: core external access stalls while bus granted
// RQ6: inhibit zero grants request; one refuses it
// RQ7: outside master waits for grant, then releases
// RQ8: level field counts queued writes zero to three
// RQ9: clock disable bit stops clock; resets zero
// RQ10: halving bit divides clock; resets to one
// RQ11: bus cycles start on clock rising edge
// RQ12: halving changes come from internal code only
// RQ13: depth zero: write stalls until complete
// RQ14: depth one: second write waits for start
// RQ15: depth two: third write waits for start
// RQ16: depth three: fourth write waits for start
// RQ17: queued writes leave in acceptance order
// RQ18: read waits for all writes, then completes
// RQ19: full queue stalls any further access
// RQ20: change depth only while queue is empty
// RQ21: config writes need protected write unlock
// RQ22: status bit shows bus grant pin level
// RQ23: timing select: 000 undivided, 001 halved
package ext_bus_pkg;
    // register map, byte addresses on the AXI4-Lite port
    localparam logic [11:0] CFG_ADDR      = 12'h000;
    // field positions of external_interface_config
    localparam int          F_DEPTH_LSB   = 0;
    localparam int          F_HALVE       = 2;
    localparam int          F_CKDIS       = 3;
    localparam int          F_LEVEL_LSB   = 6;
    localparam int          F_INHIBIT     = 9;
    localparam int          F_REQ         = 10;
    localparam int          F_GRANT       = 11;
    localparam int          F_TSEL_LSB    = 16;
    // reset values
    localparam logic [2:0]  TSEL_RST      = 3'h1;
    localparam logic        HALVE_RST     = 1'h1;
    localparam logic        CKDIS_RST     = 1'h0;
    localparam logic        INHIBIT_RST   = 1'h0;
    localparam logic [1:0]  DEPTH_RST     = 2'h0;
    // timing clock select codes
    localparam logic [2:0]  TSEL_DIV1     = 3'h0;
    // axi response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // write queue storage
    localparam int          QUEUE_SLOTS   = 3;
    localparam logic [1:0]  LAST_SLOT     = 2'h2;
endpackage

// *** dv/ext_bus_far_model.sv ***
// far side model: bus timing engine and outside bus master
`timescale 1ns/10ps
`default_nettype none
module ext_bus_far_model (
    input  wire logic        aclk,
    input  wire logic        ext_start,
    input  wire logic [15:0] ext_addr,
    output logic             ext_done,
    output logic [15:0]      ext_rdata,
    input  wire logic [7:0]  lat,           // cycles from start to done
    input  wire logic        take_bus,      // outside master wants the bus
    output logic             bus_request_n
);
    logic [7:0] cnt_q;                      // cycles left in the bus cycle
    initial begin
        cnt_q = 8'h00;
        ext_done = 1'b0;
        ext_rdata = 16'h0000;
        bus_request_n = 1'b1;
    end
    // data scrambles every cycle outside done, so stale reads show up
    always @(posedge aclk) begin
        ext_done <= 1'b0;
        ext_rdata <= ~ext_rdata;
        if (ext_start) begin
            cnt_q <= lat;
        end else if (cnt_q == 8'h01) begin
            cnt_q <= 8'h00;
            ext_done <= 1'b1;
            ext_rdata <= ext_addr ^ 16'hA5A5;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    // request held low until released; never drives the bus itself
    always @(posedge aclk) bus_request_n <= !take_bus;
endmodule
`default_nettype wire

// *** dv/ext_bus_hold_and_write_buffer_ctrl_tb_top.sv ***
// self-checking bench for the bus hold and write queue block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ext_bus_hold_and_write_buffer_ctrl_tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, unlock;
    logic        awready, wready, bvalid, arready, rvalid, cpu_req, cpu_we, cpu_ready;
    logic        ext_start, ext_we, ext_done, grant_n, hiz, xclk, tclk, req_n, take_bus, clk_q;
    logic [1:0]  bresp, rresp;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, ext_addr, ext_wdata, ext_rdata, rd;
    logic [7:0]  lat;
    int          fail_count, compares, n_start, n_done, ns, nd, nd0, s0, r, t, k;
    logic [15:0] starts[$];                 // addresses in bus order
    ext_bus_hold_and_write_buffer_ctrl u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .protected_write_unlock(unlock), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
        .cpu_rdata(cpu_rdata), .ext_start(ext_start), .ext_we(ext_we), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_done(ext_done), .ext_rdata(ext_rdata),
        .bus_request_n(req_n), .bus_grant_n(grant_n), .bus_hiz(hiz),
        .ext_bus_clock_out(xclk), .timing_clock(tclk));
    ext_bus_far_model u_far (.aclk(aclk), .ext_start(ext_start), .ext_addr(ext_addr),
        .ext_done(ext_done), .ext_rdata(ext_rdata), .lat(lat), .take_bus(take_bus),
        .bus_request_n(req_n));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // bus cycle log; a start must sit on a rising bus clock edge
    always @(posedge aclk) begin
        clk_q <= xclk;
        if (ext_done) n_done <= n_done + 1;
        if (ext_start) begin
            n_start <= n_start + 1;
            starts.push_back(ext_addr);
            `CHK({xclk, clk_q}, 2'b10)
            `CHK(ext_we, ext_addr < 16'h0300)
            if (ext_we) `CHK(ext_wdata, ~ext_addr)
        end
    end
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // a wait that ran out of cycles ends the run
    task automatic tmo(input int n);
        if (n >= 600) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 600; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(n);
        `CHK(bresp, er)
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 600; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        v = rdata;
        tmo(n);
        `CHK(rresp, ext_bus_pkg::RESP_OKAY)
    endtask
    task automatic cpu(input logic we, input logic [15:0] a, output logic [15:0] v);
        int n;
        @(posedge aclk);
        cpu_req <= 1'b1;
        cpu_we <= we;
        cpu_addr <= a;
        cpu_wdata <= ~a;
        for (n = 0; n < 600; n++) begin
            @(posedge aclk);
            if (cpu_ready) break;
        end
        cpu_req <= 1'b0;
        ns = n_start + int'(ext_start);
        nd = n_done + int'(ext_done);
        v = cpu_rdata;
        tmo(n);
    endtask
    // bus clock rises and timing ticks over 64 cycles
    task automatic rises;
        r = 0;
        t = 0;
        repeat (64) begin
            @(posedge aclk);
            if (xclk && !clk_q) r++;
            if (tclk) t++;
        end
    endtask
    task automatic wait_grant;
        for (k = 0; k < 600 && grant_n; k++) @(posedge aclk);
        tmo(k);
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, cpu_req, cpu_we, take_bus} = 8'h00;
        {awaddr, araddr, wdata, cpu_addr, cpu_wdata} = '0;
        {fail_count, compares, n_start, n_done} = '0;
        aresetn = 1'b0;
        unlock = 1'b1;
        lat = 8'h0A;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(12'h000, d);
        `CHK(d, 32'h0001_0C04)
        axi_wr(12'h004, 32'h0000_0003, ext_bus_pkg::RESP_SLVERR);
        unlock <= 1'b0;
        axi_wr(12'h000, 32'h0000_0003, ext_bus_pkg::RESP_OKAY);
        unlock <= 1'b1;
        axi_rd(12'h000, d);
        `CHK(d[1:0], 2'h0)
        $display("test registers done");
        rises();
        `CHK({r, t}, {32'd8, 32'd32})
        // timing select set to 000 over the register port; halving stays on
        axi_wr(12'h000, 32'h0000_0004, ext_bus_pkg::RESP_OKAY);
        rises();
        `CHK({r, t}, {32'd16, 32'd64})
        axi_wr(12'h000, 32'h0001_0000, ext_bus_pkg::RESP_OKAY);
        rises();
        `CHK(r, 16)
        axi_wr(12'h000, 32'h0001_0008, ext_bus_pkg::RESP_OKAY);
        rises();
        `CHK(r, 0)
        axi_wr(12'h000, 32'h0001_0004, ext_bus_pkg::RESP_OKAY);
        $display("test clocks done");
        nd0 = n_done;
        cpu(1'b1, 16'h0100, rd);
        `CHK(nd - nd0, 1)
        lat = 8'h3C;
        for (int q = 1; q < 4; q++) begin
            // depth only changed while the queue is empty
            axi_wr(12'h000, 32'h0001_0004 | q, ext_bus_pkg::RESP_OKAY);
            starts.delete();
            s0 = n_start;
            nd0 = n_done;
            for (int i = 0; i <= q; i++) cpu(1'b1, 16'h0200 + 16'(16 * q + i), rd);
            `CHK(ns != s0, 1'b1)
            axi_rd(12'h000, d);
            `CHK(d[7:6], 2'(q))
            cpu(1'b0, 16'h0300, rd);
            `CHK(rd, 16'h0300 ^ 16'hA5A5)
            `CHK(nd - nd0, q + 2)
            for (int i = 0; i <= q; i++) `CHK(starts[i], 16'h0200 + 16'(16 * q + i))
        end
        $display("test write queue done");
        lat = 8'h04;
        take_bus <= 1'b1;
        wait_grant();
        `CHK(hiz, 1'b1)
        axi_rd(12'h000, d);
        `CHK(d[11:10], 2'b00)
        fork
            cpu(1'b0, 16'h0400, rd);
            begin
                repeat (20) begin
                    @(posedge aclk);
                    `CHK(cpu_ready, 1'b0)
                end
                take_bus <= 1'b0;
            end
        join
        `CHK(rd, 16'h0400 ^ 16'hA5A5)
        take_bus <= 1'b1;
        wait_grant();
        axi_wr(12'h000, 32'h0001_0204, ext_bus_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(hiz, 1'b0)
        repeat (20) begin
            @(posedge aclk);
            `CHK(grant_n, 1'b1)
        end
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK({grant_n, hiz}, 2'b01)
        take_bus <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(12'h000, d);
        `CHK(d, 32'h0001_0C04)
        $display("test bus hold done");
        stop_test();
    end
endmodule
`default_nettype wire
